// *** bench/caa_host_bfm.sv ***
// AXI4-Lite host model that drives the datapath's register slave
`default_nettype none

module caa_host_bfm (
  // Clock
  input  wire logic                     mclk,
  // Bus towards the slave
  output var  caa_pkg::caa_axi_req_type axi_req,
  input  wire caa_pkg::caa_axi_rsp_type axi_rsp
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Idle bus from time zero
  // ---------------------------------------------------------------
  initial axi_req = '0;

  // Address and data offered together, each released when taken
  task automatic write(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] resp);
    logic aw_ok;  // Address taken
    logic w_ok;   // Data taken
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge mclk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (!aw_ok && axi_rsp.awready) begin
        aw_ok = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (!w_ok && axi_rsp.wready) begin
        w_ok = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
    end
    // Ready held up until the answer is seen at an edge
    do @(posedge mclk); while (!axi_rsp.bvalid);
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  // Address held until taken, data captured at the answering edge
  task automatic read(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] resp);
    @(posedge mclk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do @(posedge mclk); while (!axi_rsp.arready);
    axi_req.arvalid <= 1'b0;
    do @(posedge mclk); while (!axi_rsp.rvalid);
    d    = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

endmodule // caa_host_bfm

`default_nettype wire

// *** bench/tb_cpu_add_abs_alu_flags.sv ***
// Self-checking bench for the add/abs datapath slice
`default_nettype none

module tb_cpu_add_abs_alu_flags;
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Wiring
  // ---------------------------------------------------------------
  logic                     mclk;        // 50 MHz
  logic                     reset_n;     // Active low
  logic                     ce;          // Held on
  caa_pkg::caa_axi_req_type axi_req;     // Host to slave
  caa_pkg::caa_axi_rsp_type axi_rsp;     // Slave to host
  logic [7:0]               flags;       // Status bits
  logic [31:0]              result;      // Last result
  logic [1:0]               resp;        // Last bus answer
  logic [31:0]              rdat;        // Last read data
  int                       fail_count;  // Mismatches
  int                       cmp_count;   // Comparisons

  caa_alu caa_alu_i (.mclk(mclk), .reset_n(reset_n), .ce(ce),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .flags(flags),
    .result(result));
  caa_host_bfm caa_host_bfm_i (.mclk(mclk), .axi_req(axi_req),
    .axi_rsp(axi_rsp));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Setup word with go; mode is {quick, sp, src idx, dest idx}
  function automatic logic [31:0] mk(input int o, input int s,
                                     input int m);
    return {23'h0, 1'b1, 4'(m), 2'(s), 2'(o)};
  endfunction

  // Load operands and status, start, judge ports and destination
  task automatic ex(input logic [31:0] c, input logic [31:0] s,
      input logic [31:0] d, input logic [7:0] fi,
      input logic [31:0] ed, input logic [7:0] ef);
    logic [31:0] m;   // Width of the result port
    logic [7:0]  fm;  // Unsigned wrap is left open after magnitude
    m  = (c[3:2] == 2'b10) ? 32'hffffffff :
         (c[3:2] == 2'b00 && !c[4] && !c[6]) ? 32'h000000ff :
         32'h0000ffff;
    fm = (c[1:0] == 2'b00) ? 8'hfe : 8'hff;
    caa_host_bfm_i.write(caa_pkg::SRC_OFS, s, resp);
    caa_host_bfm_i.write(caa_pkg::DST_OFS, d, resp);
    caa_host_bfm_i.write(caa_pkg::FLAG_OFS, {24'h0, fi}, resp);
    caa_host_bfm_i.write(caa_pkg::CTRL_OFS, c, resp);
    #1;
    chk({24'h0, flags & fm}, {24'h0, ef & fm});
    chk(result, ed & m);
    caa_host_bfm_i.read(caa_pkg::DST_OFS, rdat, resp);
    chk(rdat, ed);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, unmapped place, read-only result
  task automatic t_bus_map();
    for (int i = 0; i < 5; i++) begin
      caa_host_bfm_i.read(8'(i * 4), rdat, resp);
      chk(rdat, caa_pkg::WORD_RST);
      chk({30'h0, resp}, {30'h0, caa_pkg::RESP_OKAY});
    end
    caa_host_bfm_i.read(8'h20, rdat, resp);
    chk({30'h0, resp}, {30'h0, caa_pkg::RESP_SLVERR});
    chk(rdat, 32'h0);
    caa_host_bfm_i.write(8'h20, 32'h5a5a5a5a, resp);
    chk({30'h0, resp}, {30'h0, caa_pkg::RESP_SLVERR});
    caa_host_bfm_i.write(caa_pkg::RES_OFS, 32'h5a5a5a5a, resp);
    caa_host_bfm_i.read(caa_pkg::RES_OFS, rdat, resp);
    chk(rdat, caa_pkg::WORD_RST);
  endtask

  // Absolute value, most negative inputs at both sizes
  task automatic t_magnitude();
    ex(mk(0,0,0), 0, 32'h12345680, 8'hd3, 32'h12345680, 8'hfa);
    ex(mk(0,0,0), 0, 32'h000000fb, 8'hd3, 32'h00000005, 8'hd2);
    ex(mk(0,1,0), 0, 32'h00008000, 8'hd2, 32'h00008000, 8'hfa);
    ex(mk(0,1,0), 0, 32'h00000000, 8'hd3, 32'h00000000, 8'hd6);
    ex(mk(0,1,0), 0, 32'h00008001, 8'hd2, 32'h00007fff, 8'hd2);
  endtask

  // Add with carry in, index register widths
  task automatic t_add_carry();
    ex(mk(1,0,0), 32'h7f, 32'h0, 8'hd3, 32'h80, 8'hfa);
    ex(mk(1,0,0), 32'hff, 32'h0, 8'hd3, 32'h00, 8'hd7);
    ex(mk(1,1,0), 32'h8000, 32'h8000, 8'hd2, 32'h0, 8'hf7);
    ex(mk(1,0,1), 32'hff, 32'h100, 8'hd3, 32'h200, 8'hd2);
    ex(mk(1,0,2), 32'h1234, 32'h1, 8'hd2, 32'h35, 8'hd2);
  endtask

  // Carry-only increment; source must be ignored
  task automatic t_carry_inc();
    ex(mk(2,1,0), 32'h1111, 32'hffff, 8'hd3, 32'h0, 8'hd7);
    ex(mk(2,0,0), 32'hff, 32'h7f, 8'hd3, 32'h80, 8'hfa);
    ex(mk(2,0,0), 32'hff, 32'h10, 8'h00, 32'h10, 8'h00);
  endtask

  // Plain add with carry set beforehand, stack, quick, long
  task automatic t_sum();
    ex(mk(3,1,0), 32'h1, 32'h7fff, 8'hd3, 32'h8000, 8'hfa);
    ex(mk(3,0,0), 32'hc0, 32'h50, 8'hd2, 32'h10, 8'hd3);
    ex(mk(3,0,1), 32'h80, 32'h1ff0, 8'hd2, 32'h2070, 8'hd2);
    ex(mk(3,0,5), 32'hfe, 32'h100, 8'hd2, 32'h1fe, 8'hd2);
    ex(mk(3,3,0), 32'h1, 32'hffff, 8'hd2, 32'h0, 8'hd7);
    ex(mk(3,0,4), 32'hfe, 32'h100, 8'hd2, 32'hfe, 8'hd3);
    ex(mk(3,1,8), 32'hf, 32'h5, 8'hd2, 32'h4, 8'hd3);
    ex(mk(3,0,8), 32'hf7, 32'h1, 8'hd3, 32'h8, 8'hd2);
    ex(mk(3,2,0), 32'h80000000, 32'h80000000, 8'hd2, 0, 8'hf7);
  endtask

  // ---------------------------------------------------------------
  // Verdict, clock, watchdog, main sequence
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Whole run needs about 450 cycles; this is over twenty times that
  initial begin
    #200us;
    fail_count++;
    test_done();
  end

  initial begin
    reset_n    = 1'b0;
    ce         = 1'b1;
    fail_count = 0;
    cmp_count  = 0;
    repeat (4) @(posedge mclk);
    chk({flags, result[23:0]}, 32'h0);
    reset_n <= 1'b1;
    t_bus_map();
    t_magnitude();
    t_add_carry();
    t_carry_inc();
    t_sum();
    test_done();
  end

endmodule // tb_cpu_add_abs_alu_flags

`default_nettype wire

// *** src/caa_alu.sv ***
// Add/abs datapath slice with its AXI4-Lite register slave
`default_nettype none

module caa_alu (
  // Clock, reset, enable
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire logic                     ce,
  // AXI4-Lite register bus
  input  wire caa_pkg::caa_axi_req_type axi_req,
  output var  caa_pkg::caa_axi_rsp_type axi_rsp,
  // Datapath state seen by the core
  output var  logic [7:0]               flags,
  output var  logic [31:0]              result
);

  // ------------------------------------------------------------------
  // State and working signals
  // ------------------------------------------------------------------
  caa_pkg::caa_state_type s_q;      // Whole registered state
  caa_pkg::caa_state_type s_d;      // Its next value
  logic [31:0]            msk;      // Ones over the effective width
  logic [31:0]            sbit;     // Sign bit of the effective width
  logic [31:0]            opa;      // Destination at width
  logic [31:0]            opb;      // Source after extension
  logic                   cin;      // Carry into the adder
  logic [32:0]            sum;      // Adder output with spare bit
  logic [31:0]            res;      // Final result at width
  logic                   ovf;      // Signed wrap
  logic                   cout;     // Unsigned wrap
  logic                   run_now;  // Execute edge helper

  assign run_now = ce && (s_q.exec == caa_pkg::EX_RUN);

  // Outputs come straight from the state flops
  assign axi_rsp = s_q.rsp;
  assign flags   = s_q.flags;
  assign result  = s_q.result;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Byte-lane merge of a bus write into a register
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // ------------------------------------------------------------------
  // Arithmetic
  // ------------------------------------------------------------------
  // Width, operand shaping, adder and flag terms
  always_comb begin : alu
    msk  = 32'hffff_ffff;
    sbit = 32'h8000_0000;
    // Byte ops widen to 16 bits for index destinations, or stack destinations of a plain sum
    case (s_q.ctrl.size)
      caa_pkg::SZ_BYTE: begin
        if (s_q.ctrl.dest_idx ||
            (s_q.ctrl.dest_sp && s_q.ctrl.op == caa_pkg::OP_SUM)) begin
          msk  = 32'h0000_ffff;
          sbit = 32'h0000_8000;
        end else begin
          msk  = 32'h0000_00ff;
          sbit = 32'h0000_0080;
        end
      end
      caa_pkg::SZ_WORD: begin
        msk  = 32'h0000_ffff;
        sbit = 32'h0000_8000;
      end
      caa_pkg::SZ_LONG: begin
        msk  = 32'hffff_ffff;
        sbit = 32'h8000_0000;
      end
      default: begin
        // Unused code behaves as word rather than hanging the core
        msk  = 32'h0000_ffff;
        sbit = 32'h0000_8000;
      end
    endcase
    opa = s_q.dst & msk;
    // Source shaping; index sources at byte size give low byte only
    // An index destination wins over the stack pointer: zero extension
    if (s_q.ctrl.quick) begin
      opb = {{28{s_q.src[3]}}, s_q.src[3:0]};
    end else if (s_q.ctrl.size == caa_pkg::SZ_BYTE &&
                 s_q.ctrl.dest_sp && !s_q.ctrl.dest_idx &&
                 s_q.ctrl.op == caa_pkg::OP_SUM) begin
      opb = {{24{s_q.src[7]}}, s_q.src[7:0]};
    end else if (s_q.ctrl.size == caa_pkg::SZ_BYTE) begin
      opb = {24'h00_0000, s_q.src[7:0]};
    end else begin
      opb = s_q.src;
    end
    // Carry-in only for the carry ops; carry increment drops source
    case (s_q.ctrl.op)
      caa_pkg::OP_ADD_CARRY: begin
        cin = s_q.flags[caa_pkg::FLG_C];
      end
      caa_pkg::OP_CARRY_INC: begin
        cin = s_q.flags[caa_pkg::FLG_C];
        opb = 32'h0000_0000;
      end
      caa_pkg::OP_SUM: begin
        cin = 1'b0;
      end
      default: begin
        cin = 1'b0;
        opb = 32'h0000_0000;
      end
    endcase
    opb = opb & msk;
    sum = {1'b0, opa} + {1'b0, opb} + {32'h0000_0000, cin};
    // Carry is the bit just above the width
    cout = |(sum[32:1] & sbit);
    if (s_q.ctrl.op == caa_pkg::OP_MAGNITUDE) begin
      // Negating the most negative value wraps back onto itself
      res = (|(opa & sbit)) ? ((~opa + 32'h0000_0001) & msk)
                            : opa;
      ovf = (opa == sbit);
    end else begin
      res = sum[31:0] & msk;
      // Equal operand signs and a flipped result sign
      ovf = ((opa & sbit) == (opb & sbit)) &&
            ((res & sbit) != (opa & sbit));
    end
  end

  // ------------------------------------------------------------------
  // Next state: bus slave and sequencer
  // ------------------------------------------------------------------
  // Bus first, then execution, so an executing op wins the registers
  always_comb begin : next_state
    s_d = s_q;
    // Response retire
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid = 1'b0;
    end
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid = 1'b0;
    end
    // Address and data are latched independently, in either order
    if (axi_req.awvalid && s_q.rsp.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && s_q.rsp.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = axi_req.wdata;
      s_d.w_strb = axi_req.wstrb;
    end
    // Sequencer returns to idle after one execute cycle
    case (s_q.exec)
      caa_pkg::EX_RUN:  s_d.exec = caa_pkg::EX_IDLE;
      caa_pkg::EX_IDLE: s_d.exec = caa_pkg::EX_IDLE;
      default:          s_d.exec = caa_pkg::EX_IDLE;
    endcase
    // Register write once both halves are held and B is free
    if (s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid) begin
      s_d.aw_have    = 1'b0;
      s_d.w_have     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = caa_pkg::RESP_OKAY;
      case (s_q.aw_addr & caa_pkg::WORD_SEL)
        caa_pkg::CTRL_OFS: begin
          if (s_q.w_strb[0]) begin
            s_d.ctrl = caa_pkg::caa_ctrl_type'(s_q.w_data[7:0]);
          end
          // Go needs lane 1; it launches with the setup just written
          if (s_q.w_strb[1] && s_q.w_data[caa_pkg::CTRL_GO]) begin
            s_d.exec = caa_pkg::EX_RUN;
          end
        end
        caa_pkg::SRC_OFS: s_d.src = merge(s_q.src, s_q.w_data,
                                          s_q.w_strb);
        caa_pkg::DST_OFS: s_d.dst = merge(s_q.dst, s_q.w_data,
                                          s_q.w_strb);
        caa_pkg::FLAG_OFS: begin
          if (s_q.w_strb[0]) begin
            s_d.flags = s_q.w_data[7:0];
          end
        end
        caa_pkg::RES_OFS: s_d.rsp.bresp = caa_pkg::RESP_OKAY;
        default:          s_d.rsp.bresp = caa_pkg::RESP_SLVERR;
      endcase
    end
    // Read: one beat at a time, data from current state
    if (axi_req.arvalid && s_q.rsp.arready) begin
      s_d.rsp.rvalid = 1'b1;
      s_d.rsp.rresp  = caa_pkg::RESP_OKAY;
      case (axi_req.araddr & caa_pkg::WORD_SEL)
        caa_pkg::CTRL_OFS: s_d.rsp.rdata = {24'h00_0000, s_q.ctrl};
        caa_pkg::SRC_OFS:  s_d.rsp.rdata = s_q.src;
        caa_pkg::DST_OFS:  s_d.rsp.rdata = s_q.dst;
        caa_pkg::FLAG_OFS: s_d.rsp.rdata = {24'h00_0000, s_q.flags};
        caa_pkg::RES_OFS:  s_d.rsp.rdata = s_q.result;
        default: begin
          s_d.rsp.rdata = caa_pkg::WORD_RST;
          s_d.rsp.rresp = caa_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Execute: write back result, update only the listed flags
    if (s_q.exec == caa_pkg::EX_RUN) begin
      s_d.dst    = (s_q.dst & ~msk) | res;
      s_d.result = res;
      s_d.flags[caa_pkg::FLG_O] = ovf;
      s_d.flags[caa_pkg::FLG_S] = |(res & sbit);
      s_d.flags[caa_pkg::FLG_Z] = (res == 32'h0000_0000);
      // Magnitude keeps the old carry, a legal undefined value
      if (s_q.ctrl.op != caa_pkg::OP_MAGNITUDE) begin
        s_d.flags[caa_pkg::FLG_C] = cout;
      end
      // U, I, B and D are never assigned here
    end
    // Ready while nothing is held or outstanding
    s_d.rsp.awready = !s_d.aw_have;
    s_d.rsp.wready  = !s_d.w_have;
    s_d.rsp.arready = !s_d.rsp.rvalid;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Readies come up at the first enabled edge after release
  always_ff @(posedge mclk or negedge reset_n) begin : state_reg
    if (!reset_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_both_taken;
    ce && axi_req.awvalid && s_q.rsp.awready &&
    axi_req.wvalid && s_q.rsp.wready && !s_q.rsp.bvalid;
  endsequence

  sequence s_run_op(caa_pkg::caa_op_type o, caa_pkg::caa_size_type z);
    run_now && s_q.ctrl.op == o && s_q.ctrl.size == z;
  endsequence

  a_write_resp: assert property (s_both_taken ##1 ce |=> s_q.rsp.bvalid)
    else $error("write not answered");
  a_sum_word: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_WORD) and !s_q.ctrl.quick
    |=> s_q.result[15:0] ==
        16'($past(s_q.dst[15:0]) + $past(s_q.src[15:0])))
    else $error("word sum wrong");
  a_adc_word: assert property (
    s_run_op(caa_pkg::OP_ADD_CARRY, caa_pkg::SZ_WORD)
    |=> s_q.result[15:0] == 16'($past(s_q.dst[15:0]) +
        $past(s_q.src[15:0]) + {15'h0000, $past(s_q.flags[0])}))
    else $error("add with carry wrong");
  a_carry_increment_op_byte: assert property (
    s_run_op(caa_pkg::OP_CARRY_INC, caa_pkg::SZ_BYTE) and
    !s_q.ctrl.dest_idx
    |=> s_q.result[7:0] ==
        8'($past(s_q.dst[7:0]) + {7'h00, $past(s_q.flags[0])}))
    else $error("carry increment wrong");
  a_abs_min: assert property (
    s_run_op(caa_pkg::OP_MAGNITUDE, caa_pkg::SZ_BYTE) and
    !s_q.ctrl.dest_idx && s_q.dst[7:0] == 8'h80
    |=> s_q.flags[caa_pkg::FLG_O] && s_q.result[7:0] == 8'h80)
    else $error("byte minimum magnitude wrong");
  a_abs_pos: assert property (
    s_run_op(caa_pkg::OP_MAGNITUDE, caa_pkg::SZ_WORD) and !s_q.dst[15]
    |=> s_q.result[15:0] == $past(s_q.dst[15:0]) &&
        !s_q.flags[caa_pkg::FLG_O])
    else $error("positive magnitude changed");
  a_index_zext: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_BYTE) and
    s_q.ctrl.dest_idx && !s_q.ctrl.quick
    |=> s_q.result[15:0] == 16'($past(s_q.dst[15:0]) +
        {8'h00, $past(s_q.src[7:0])}))
    else $error("index destination not zero-extended");
  a_sp_sext: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_BYTE) and s_q.ctrl.dest_sp &&
    !s_q.ctrl.dest_idx && !s_q.ctrl.quick
    |=> s_q.result[15:0] == 16'($past(s_q.dst[15:0]) +
        {{8{$past(s_q.src[7])}}, $past(s_q.src[7:0])}))
    else $error("stack source not sign-extended");
  a_quick_imm: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_WORD) and s_q.ctrl.quick
    |=> s_q.result[15:0] == 16'($past(s_q.dst[15:0]) +
        {{12{$past(s_q.src[3])}}, $past(s_q.src[3:0])}))
    else $error("quick immediate wrong");
  a_byte_carry: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_BYTE) and !s_q.ctrl.dest_idx &&
    !s_q.ctrl.dest_sp && !s_q.ctrl.quick
    |=> s_q.flags[caa_pkg::FLG_C] == (({1'b0, $past(s_q.dst[7:0])} +
        {1'b0, $past(s_q.src[7:0])}) > 9'h0ff))
    else $error("byte carry wrong");
  a_word_ovf: assert property (
    s_run_op(caa_pkg::OP_SUM, caa_pkg::SZ_WORD) and !s_q.ctrl.quick
    |=> s_q.flags[caa_pkg::FLG_O] ==
        (($past(s_q.dst[15]) == $past(s_q.src[15])) &&
         (s_q.result[15] != $past(s_q.dst[15]))))
    else $error("word overflow wrong");
  a_neg_zero: assert property (
    run_now && s_q.ctrl.size == caa_pkg::SZ_WORD
    |=> s_q.flags[caa_pkg::FLG_S] == s_q.result[15] &&
        s_q.flags[caa_pkg::FLG_Z] == (s_q.result[15:0] == 16'h0000))
    else $error("negative or zero flag wrong");
  a_keep_flags: assert property (
    run_now |=> {s_q.flags[7:6], s_q.flags[4], s_q.flags[1]} ==
        {$past(s_q.flags[7:6]), $past(s_q.flags[4]),
         $past(s_q.flags[1])})
    else $error("unlisted flag changed");

endmodule // caa_alu

`default_nettype wire

// *** src/caa_pkg.sv ***
// Constants, enumerations and carrier types of the add/abs datapath slice
`default_nettype none

package caa_pkg;

  // ------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ------------------------------------------------------------------
  localparam int          ADDR_W   = 8;
  localparam logic [7:0]  CTRL_OFS = 8'h00;  // Operation setup and go
  localparam logic [7:0]  SRC_OFS  = 8'h04;  // Source operand
  localparam logic [7:0]  DST_OFS  = 8'h08;  // Destination operand
  localparam logic [7:0]  FLAG_OFS = 8'h0c;  // Status bits
  localparam logic [7:0]  RES_OFS  = 8'h10;  // Last result, read only
  localparam logic [7:0]  WORD_SEL = 8'hfc;  // Drops the byte offset

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_W     = 8;  // Stored setup bits 7:0
  localparam int CTRL_GO    = 8;  // Write-only start bit
  localparam int FLG_C      = 0;  // Unsigned wrap
  localparam int FLG_D      = 1;  // Debug
  localparam int FLG_Z      = 2;  // Null result
  localparam int FLG_S      = 3;  // Negative
  localparam int FLG_B      = 4;  // Register bank
  localparam int FLG_O      = 5;  // Signed wrap
  localparam int FLG_I      = 6;  // Interrupt enable
  localparam int FLG_U      = 7;  // Stack select

  // ------------------------------------------------------------------
  // Reset values and bus answers
  // ------------------------------------------------------------------
  localparam logic [7:0]  FLAG_RST    = 8'h00;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ------------------------------------------------------------------
  // Operations, sizes, sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_MAGNITUDE = 2'b00,  // Absolute value
    OP_ADD_CARRY = 2'b01,  // dest + src + C
    OP_CARRY_INC = 2'b10,  // dest + C
    OP_SUM       = 2'b11   // dest + src
  } caa_op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } caa_size_type;

  typedef enum logic {
    EX_IDLE = 1'b0,
    EX_RUN  = 1'b1
  } caa_exec_type;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic         quick;     // Bit 7: 4-bit signed immediate
    logic         dest_sp;   // Bit 6: destination is stack pointer
    logic         src_idx;   // Bit 5: source is an index register
    logic         dest_idx;  // Bit 4: destination is an index register
    caa_size_type size;      // Bits 3:2
    caa_op_type   op;        // Bits 1:0
  } caa_ctrl_type;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } caa_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } caa_axi_rsp_type;

  typedef struct packed {
    caa_axi_rsp_type   rsp;
    logic              aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    caa_ctrl_type      ctrl;
    logic [31:0]       src;
    logic [31:0]       dst;
    logic [7:0]        flags;
    logic [31:0]       result;
    caa_exec_type      exec;
  } caa_state_type;

endpackage

`default_nettype wire
